// ---- core/mlfc_pkg.sv ----
// package for the multi-line card feed sequencer
// assumes one system clock, card cycles marked by an index pulse
package mlfc_pkg;
	localparam int MLFC_CLK_HZ = 25000000;
	localparam int MLFC_FIELD_COLS = 24;
	localparam int MLFC_DIGIT_W = 4;
	localparam int MLFC_FIFO_DEPTH = 8;
	localparam int MLFC_STACKER_CAP = 1000;
	localparam logic [8:0] MLFC_HOLD_DEG = 9'h0A5;
	localparam logic [1:0] MLFC_LATCH_RST = 2'h0;

	// card class from the control column
	typedef enum logic [2:0]
	{
		MLFC_NORMAL = 3'h0,
		MLFC_ONE = 3'h1,
		MLFC_TWO = 3'h2,
		MLFC_THREE = 3'h3,
		MLFC_ONE_NO_IDLE = 3'h4,
		MLFC_CODE_ERR = 3'h5
	} mlfc_class_t;

	typedef enum logic [1:0]
	{
		MLFC_ST_STOP = 2'h0,
		MLFC_ST_RUN = 2'h1,
		MLFC_ST_HOLD = 2'h2,
		MLFC_ST_IDLE = 2'h3
	} mlfc_state_t;

	// control column punches, rows 9, 8 and 4..1 as bits
	typedef struct packed
	{
		logic p9;
		logic p8;
		logic p4;
		logic p3;
		logic p2;
		logic p1;
	} mlfc_ctrl_col_t;

	// one third-line digit handed to the print side
	typedef struct packed
	{
		logic [4:0] col;
		logic [3:0] digit;
	} mlfc_digit_t;
endpackage

// ---- core/mlfc_fifo.sv ----
// small flip-flop FIFO, valid/ready on both sides
// assumes a single clock and a synchronous-use clock enable
`timescale 1ns/1ns
`default_nettype none
module mlfc_fifo
	import mlfc_pkg::*;
#(
	parameter int WIDTH = 9,
	parameter int DEPTH = MLFC_FIFO_DEPTH
)
(
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic ce_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic [AW:0] next_count;
	logic push;
	logic pop;

	// empty from the count; ready is registered from the next count
	assign out_valid_out = (count != '0);
	assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
	assign out_data_out = mem[rd_ptr];
	assign push = ce_in && in_valid_in && in_ready_out;
	assign pop = ce_in && out_valid_out && out_ready_in;

	// storage written by index, not reset
	always_ff @(posedge clk_in)
	begin
		if (push)
			mem[wr_ptr] <= in_data_in;
	end

	// pointers wrap on depth
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			in_ready_out <= 1'b1;
		end
		else
		begin
			if (push)
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			if (ce_in)
			begin
				count <= next_count;
				// full flag from a flop keeps the top's ready registered
				in_ready_out <= (next_count != DEPTH[AW:0]);
			end
		end
	end
endmodule
`default_nettype wire

// ---- core/mlfc_top.sv ----
// card feed sequencer for a three-station multi-line card reader
// assumes index angle and card-cycle pulse come from the feed, all sync
`timescale 1ns/1ns
`default_nettype none
module mlfc_top
	import mlfc_pkg::*;
#(
	parameter int FIELD_COLS = MLFC_FIELD_COLS,
	parameter int FIFO_DEPTH = MLFC_FIFO_DEPTH
)
(
	input wire logic CLK_SYS_IN,
	input wire logic ARST_N_IN,
	input wire logic CE_IN,
	input wire logic START_IN,
	input wire logic HOPPER_EMPTY_IN,
	input wire logic STACKER_FULL_IN,
	input wire logic CYCLE_PULSE_IN,
	input wire logic [8:0] INDEX_DEG_IN,
	input wire logic CTRL_VALID_IN,
	input wire mlfc_ctrl_col_t CTRL_COL_IN,
	input wire logic [1:0] FIELD_ORDER_IN [3],
	input wire logic DIGIT_VALID_IN,
	output logic DIGIT_READY_OUT,
	input wire mlfc_digit_t DIGIT_IN,
	input wire logic PRINT_READY_IN,
	output logic PRINT_VALID_OUT,
	output mlfc_digit_t PRINT_DIGIT_OUT,
	output logic RUN_OUT,
	output logic FEED_KNIFE_CLUTCH_OUT,
	output logic IDLE_CYCLE_OUT,
	output logic [1:0] LINE_COUNT_OUT,
	output logic [1:0] ZONE_SEL_OUT,
	output logic [1:0] COMPARE_STN_OUT,
	output logic CODE_ERR_OUT
);
	mlfc_state_t state;
	mlfc_state_t next_state;
	mlfc_class_t cur_class;
	mlfc_class_t new_class;
	mlfc_class_t next_class;
	logic [1:0] latch_left;
	logic [1:0] next_latch;
	logic idle_left;
	logic next_idle;
	logic [1:0] line_idx;
	logic line_card;
	logic fifo_valid;
	mlfc_digit_t fifo_data;
	logic hold_digits;
	logic fifo_pop_ready;

	// decode control column; 9-8 needed for any line class
	// the line-count punch is taken lowest first, so a doubly
	// punched column still resolves to one class
	always_comb
	begin
		next_class = MLFC_NORMAL;
		if (CTRL_COL_IN.p9 && CTRL_COL_IN.p8)
		begin
			if (CTRL_COL_IN.p1)
				next_class = MLFC_ONE;
			else if (CTRL_COL_IN.p2)
				next_class = MLFC_TWO;
			else if (CTRL_COL_IN.p3)
				next_class = MLFC_THREE;
			else if (CTRL_COL_IN.p4)
				next_class = MLFC_ONE_NO_IDLE;
			else
				next_class = MLFC_CODE_ERR;
		end
	end

	// new card is a line card when class one to three
	// a 9-8-4 card counts as normal here: it never makes
	// the card ahead of it wait
	assign line_card = (new_class == MLFC_ONE) ||
		(new_class == MLFC_TWO) || (new_class == MLFC_THREE);

	// latch and idle counts from previous and following classes
	// pure table lookup; only sampled at a card-cycle boundary,
	// so glitches while the control column settles do no harm
	// error cards fall into the default and never hold the feed
	always_comb
	begin
		next_latch = 2'h0;
		next_idle = 1'b0;
		case (cur_class)
			MLFC_NORMAL:
				next_latch = line_card ? 2'h1 : 2'h0;
			MLFC_ONE:
				next_idle = (new_class == MLFC_NORMAL);
			MLFC_TWO:
				next_latch = line_card ? 2'h1 : 2'h0;
			MLFC_THREE:
				next_latch = line_card ? 2'h2 : 2'h1;
			MLFC_ONE_NO_IDLE:
				next_latch = line_card ? 2'h1 : 2'h0;
			default:
				next_latch = 2'h0;
		endcase
	end

	// run state: start, stops, hold and idle cycles
	// stacker full wins over everything so no card is pushed
	// into a full stack; hopper empty is only seen at a boundary
	// so the card in flight always completes its cycle
	always_comb
	begin
		next_state = state;
		case (state)
			MLFC_ST_STOP:
				if (START_IN && !STACKER_FULL_IN)
					next_state = MLFC_ST_RUN;
			MLFC_ST_RUN:
				if (STACKER_FULL_IN)
					next_state = MLFC_ST_STOP;
				else if (CYCLE_PULSE_IN && HOPPER_EMPTY_IN)
					next_state = MLFC_ST_STOP;
				else if (CYCLE_PULSE_IN && next_latch != 2'h0)
					next_state = MLFC_ST_HOLD;
				else if (CYCLE_PULSE_IN && next_idle)
					next_state = MLFC_ST_IDLE;
			MLFC_ST_HOLD:
				if (STACKER_FULL_IN)
					next_state = MLFC_ST_STOP;
				else if (CYCLE_PULSE_IN && latch_left == 2'h1)
					next_state = MLFC_ST_RUN;
			MLFC_ST_IDLE:
				if (STACKER_FULL_IN)
					next_state = MLFC_ST_STOP;
				else if (CYCLE_PULSE_IN)
					next_state = MLFC_ST_RUN;
			default:
				next_state = MLFC_ST_STOP;
		endcase
	end

	// state register
	// frozen with the clock enable like every other flop
	always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
			state <= MLFC_ST_STOP;
		else if (CE_IN)
			state <= next_state;
	end

	// capture control column class when read at the first station
	// a held card is not read again, so its class waits here
	// until the feed resumes
	always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
			new_class <= MLFC_NORMAL;
		else if (CE_IN && CTRL_VALID_IN)
			new_class <= next_class;
	end

	// classes shift at each card-cycle boundary while feeding
	// no shift during hold or idle: the cards do not move then,
	// and shifting would lose the pairing of neighbours
	always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
			cur_class <= MLFC_NORMAL;
		else if (CE_IN && CYCLE_PULSE_IN && state == MLFC_ST_RUN)
			cur_class <= new_class;
	end

	// latch cycle counter; loaded on entry, counts each held cycle
	// two bits suffice, at most two held cycles per card pair
	always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
			latch_left <= MLFC_LATCH_RST;
		else if (CE_IN && CYCLE_PULSE_IN)
		begin
			if (state == MLFC_ST_RUN)
				latch_left <= next_latch;
			else if (state == MLFC_ST_HOLD && latch_left != 2'h0)
				latch_left <= latch_left - 2'h1;
		end
	end

	// idle flag kept for the one lost cycle
	// stretches the idle status one clock past the boundary
	always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
			idle_left <= 1'b0;
		else if (CE_IN && CYCLE_PULSE_IN)
			idle_left <= (state == MLFC_ST_RUN) && next_idle;
	end

	// clutch latches at 165 degrees only while holding
	// latching at the angle parks the next card between its 1 and
	// 0 rows; latching earlier would leave it short of the brushes
	always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
			FEED_KNIFE_CLUTCH_OUT <= 1'b0;
		else if (CE_IN)
		begin
			if (state == MLFC_ST_HOLD && INDEX_DEG_IN == MLFC_HOLD_DEG)
				FEED_KNIFE_CLUTCH_OUT <= 1'b1;
			else if (state != MLFC_ST_HOLD)
				FEED_KNIFE_CLUTCH_OUT <= 1'b0;
		end
	end

	// line selector cycles per printed line of the current card
	// saturates at the third line; reset at each boundary while feeding
	always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
			line_idx <= 2'h0;
		else if (CE_IN && CYCLE_PULSE_IN)
		begin
			if (state == MLFC_ST_RUN)
				line_idx <= 2'h0;
			else if (state == MLFC_ST_HOLD && line_idx != 2'h2)
				line_idx <= line_idx + 2'h1;
		end
	end

	// registered status outputs
	// all levels, one cycle behind their cause, so the far side
	// never sees a combinational glitch
	always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
		begin
			RUN_OUT <= 1'b0;
			IDLE_CYCLE_OUT <= 1'b0;
			LINE_COUNT_OUT <= 2'h0;
			ZONE_SEL_OUT <= 2'h0;
			COMPARE_STN_OUT <= 2'h0;
			CODE_ERR_OUT <= 1'b0;
		end
		else if (CE_IN)
		begin
			RUN_OUT <= (next_state != MLFC_ST_STOP);
			IDLE_CYCLE_OUT <= (next_state == MLFC_ST_IDLE) || idle_left;
			case (cur_class)
				MLFC_ONE, MLFC_ONE_NO_IDLE:
					LINE_COUNT_OUT <= 2'h1;
				MLFC_TWO:
					LINE_COUNT_OUT <= 2'h2;
				MLFC_THREE:
					LINE_COUNT_OUT <= 2'h3;
				default:
					LINE_COUNT_OUT <= 2'h0;
			endcase
			// field placement is free; table maps line to field slot
			ZONE_SEL_OUT <= FIELD_ORDER_IN[line_idx];
			// station pair: 0 means 1-2 compare, 1 means 2-3
			if (cur_class == MLFC_NORMAL && new_class == MLFC_NORMAL)
				COMPARE_STN_OUT <= 2'h1;
			else
				COMPARE_STN_OUT <= 2'h0;
			if (CTRL_VALID_IN && next_class == MLFC_CODE_ERR)
				CODE_ERR_OUT <= 1'b1;
			else if (START_IN)
				CODE_ERR_OUT <= 1'b0;
		end
	end

	// third-line digits are held until the next cycle boundary
	// phase toggles each card cycle: one cycle collecting, one
	// releasing, which stands in for the storage counters
	// limitation: the phase is free running, not tied to a card
	always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
			hold_digits <= 1'b1;
		else if (CE_IN && CYCLE_PULSE_IN)
			hold_digits <= ~hold_digits;
	end

	// column index limits fields to FIELD_COLS columns
	// pop only while releasing and the print register is free
	// or being emptied in the same cycle
	assign fifo_pop_ready = !hold_digits && (!PRINT_VALID_OUT || PRINT_READY_IN);

	mlfc_fifo #(
		.WIDTH($bits(mlfc_digit_t)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_in(CLK_SYS_IN),
		.arst_n_in(ARST_N_IN),
		.ce_in(CE_IN),
		.in_valid_in(DIGIT_VALID_IN && (DIGIT_IN.col < 5'(FIELD_COLS))),
		.in_ready_out(DIGIT_READY_OUT),
		.in_data_in(DIGIT_IN),
		.out_valid_out(fifo_valid),
		.out_ready_in(fifo_pop_ready),
		.out_data_out(fifo_data)
	);

	// print output register; loaded from the FIFO only in the releasing phase
	// holds value and valid through any stall of the print side
	always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
		begin
			PRINT_VALID_OUT <= 1'b0;
			PRINT_DIGIT_OUT <= '0;
		end
		else if (CE_IN)
		begin
			if (fifo_valid && fifo_pop_ready)
			begin
				PRINT_VALID_OUT <= 1'b1;
				PRINT_DIGIT_OUT <= fifo_data;
			end
			else if (PRINT_READY_IN)
				PRINT_VALID_OUT <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ---- tb/mlfc_feed_model.sv ----
// feed side model: index angle, card-cycle pulse, print ready
// assumes the sequencer samples all of these on the rising edge
`timescale 1ns/1ns
`default_nettype none
module mlfc_feed_model
#(
	parameter int STEP = 15
)
(
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic stall_in,
	output logic pulse_out,
	output logic [8:0] index_out,
	output logic print_ready_out
);
	logic wrap;
	assign wrap = index_out >= 9'(360 - STEP);
	// shaft keeps turning while the knife clutch holds the card
	// no heading cards are fed, so their kinds never mix
	always_ff @(posedge clk_in or negedge arst_n_in)
		if (!arst_n_in)
		begin
			index_out <= 9'h000;
			pulse_out <= 1'b0;
			print_ready_out <= 1'b0;
		end
		else
		begin
			index_out <= wrap ? 9'h000 : index_out + 9'(STEP);
			pulse_out <= wrap;
			print_ready_out <= !stall_in; // stalls lag one cycle
		end
endmodule
`default_nettype wire

// ---- tb/mlfc_top_chk.sv ----
// port assertions for the card feed sequencer
// assumes one clock, async active-low reset, bound below
`timescale 1ns/1ns
`default_nettype none
module mlfc_top_chk
	import mlfc_pkg::*;
(
	input wire logic CLK_SYS_IN,
	input wire logic ARST_N_IN,
	input wire logic START_IN,
	input wire logic HOPPER_EMPTY_IN,
	input wire logic STACKER_FULL_IN,
	input wire logic CYCLE_PULSE_IN,
	input wire logic [8:0] INDEX_DEG_IN,
	input wire logic CTRL_VALID_IN,
	input wire mlfc_ctrl_col_t CTRL_COL_IN,
	input wire logic PRINT_READY_IN,
	input wire logic PRINT_VALID_OUT,
	input wire mlfc_digit_t PRINT_DIGIT_OUT,
	input wire logic RUN_OUT,
	input wire logic FEED_KNIFE_CLUTCH_OUT,
	input wire logic IDLE_CYCLE_OUT,
	input wire logic CODE_ERR_OUT
);
	default clocking cb @(posedge CLK_SYS_IN);
	endclocking
	default disable iff (!ARST_N_IN);
	logic bad_col;
	logic steady;
	// 9-8 punched with no line count
	assign bad_col = CTRL_COL_IN[5:4] == 2'h3 && CTRL_COL_IN[3:0] == 4'h0;
	// plain running, neither held nor idling
	assign steady = RUN_OUT && !FEED_KNIFE_CLUTCH_OUT && !IDLE_CYCLE_OUT;
	a_clutch_at_index: assert property (
		$rose(FEED_KNIFE_CLUTCH_OUT) |-> $past(INDEX_DEG_IN) == MLFC_HOLD_DEG)
		else $error("clutch latched off the hold angle");
	a_stacker_stop: assert property (
		STACKER_FULL_IN |=> !RUN_OUT)
		else $error("still running with stacker full");
	a_start_blocked: assert property (
		STACKER_FULL_IN && !RUN_OUT |=> !RUN_OUT [*1])
		else $error("start taken with stacker full");
	a_start_runs: assert property (
		START_IN && !STACKER_FULL_IN && !CYCLE_PULSE_IN |=> RUN_OUT)
		else $error("start did not run");
	a_hopper_stop: assert property (
		HOPPER_EMPTY_IN && CYCLE_PULSE_IN && steady && !START_IN |=> !RUN_OUT)
		else $error("no stop on empty hopper");
	a_code_error: assert property (
		CTRL_VALID_IN && bad_col |=> CODE_ERR_OUT)
		else $error("bad control column not flagged");
	a_idle_unlatched: assert property (
		!(IDLE_CYCLE_OUT && FEED_KNIFE_CLUTCH_OUT))
		else $error("idle cycle with clutch latched");
	a_print_held: assert property (
		PRINT_VALID_OUT && !PRINT_READY_IN |=>
		PRINT_VALID_OUT && $stable(PRINT_DIGIT_OUT))
		else $error("print digit dropped while stalled");
endmodule
bind mlfc_top mlfc_top_chk u_chk
(
	.CLK_SYS_IN,
	.ARST_N_IN,
	.START_IN,
	.HOPPER_EMPTY_IN,
	.STACKER_FULL_IN,
	.CYCLE_PULSE_IN,
	.INDEX_DEG_IN,
	.CTRL_VALID_IN,
	.CTRL_COL_IN,
	.PRINT_READY_IN,
	.PRINT_VALID_OUT,
	.PRINT_DIGIT_OUT,
	.RUN_OUT,
	.FEED_KNIFE_CLUTCH_OUT,
	.IDLE_CYCLE_OUT,
	.CODE_ERR_OUT
);
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the card feed sequencer
// assumes the package, design, checker and feed model compiled first
`timescale 1ns/1ns
`default_nettype none
module tb_top
	import mlfc_pkg::*;
();
	logic clk, arst_n, start, hopper, stacker, cv, stall, dv, held;
	logic pulse, pready, rdy, pv, run, clutch, idle, err;
	logic [8:0] index, digit;
	logic [5:0] col;
	mlfc_digit_t pd;
	logic [1:0] order [3];
	logic [1:0] lc, zs, cs;
	int mismatches, checks, n_lat, n_idl;
	mlfc_top u_dut
	(
		.CLK_SYS_IN(clk), .ARST_N_IN(arst_n), .CE_IN(1'b1),
		.START_IN(start), .HOPPER_EMPTY_IN(hopper),
		.STACKER_FULL_IN(stacker), .CYCLE_PULSE_IN(pulse),
		.INDEX_DEG_IN(index), .CTRL_VALID_IN(cv), .CTRL_COL_IN(col),
		.FIELD_ORDER_IN(order), .DIGIT_VALID_IN(dv),
		.DIGIT_READY_OUT(rdy), .DIGIT_IN(digit),
		.PRINT_READY_IN(pready), .PRINT_VALID_OUT(pv),
		.PRINT_DIGIT_OUT(pd), .RUN_OUT(run),
		.FEED_KNIFE_CLUTCH_OUT(clutch), .IDLE_CYCLE_OUT(idle),
		.LINE_COUNT_OUT(lc), .ZONE_SEL_OUT(zs), .COMPARE_STN_OUT(cs),
		.CODE_ERR_OUT(err)
	);
	mlfc_feed_model u_feed
	(
		.clk_in(clk), .arst_n_in(arst_n), .stall_in(stall),
		.pulse_out(pulse), .index_out(index), .print_ready_out(pready)
	);
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// tally held and idle card cycles at each boundary
	always @(posedge clk)
		if (pulse)
		begin
			n_lat += int'(clutch);
			n_idl += int'(idle);
			held = clutch;
		end
	task automatic chk(input string what, input logic [8:0] seen, exp);
		checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// control column of a class: 0 normal, 1..3 lines, 4 no-idle
	function automatic logic [5:0] code(input int k);
		return (k == 0) ? 6'h00 : (k == 4) ? 6'h38 : 6'h30 | 6'(1 << (k - 1));
	endfunction
	function automatic int lat(input int a, b);
		// a 9-8-4 card follows like a normal card
		if (b == 0 || b == 4)
			return (a == 3) ? 1 : 0;
		return (a == 1) ? 0 : (a == 3) ? 2 : 1;
	endfunction
	// feed normal, a, b, normals; a held card is not read again
	task automatic run_seq(input int a, b);
		int c [6];
		int el, ei, j;
		c = '{0, a, b, 0, 0, 0};
		el = 0;
		ei = 0;
		for (j = 0; j < 5; j++)
		begin
			el += lat(c[j], c[j + 1]);
			ei += int'(c[j] == 1 && c[j + 1] == 0);
		end
		n_lat = 0;
		n_idl = 0;
		j = 0;
		repeat (14)
		begin
			if (!held)
			begin
				col = code(j < 6 ? c[j] : 0);
				cv = 1'b1;
				j++;
			end
			@(posedge clk);
			#1 cv = 1'b0;
			@(posedge clk iff pulse);
			#1;
		end
		chk("latched", 9'(n_lat), 9'(el));
		chk("idle", 9'(n_idl), 9'(ei));
	endtask
	task automatic t_pairs();
		for (int a = 0; a < 5; a++)
			for (int b = 0; b < 5; b++)
				run_seq(a, b);
		$display("pairs done");
	endtask
	// line count, station pair and zone slot around a three-line card
	task automatic t_status();
		chk("line count", 9'(lc), 9'h000);
		chk("compare pair", 9'(cs), 9'h001);
		chk("zone slot", 9'(zs), 9'(order[0]));
		col = code(3);
		cv = 1'b1;
		@(posedge clk);
		#1 cv = 1'b0;
		@(posedge clk iff pulse);
		@(posedge clk);
		#1 chk("three lines", 9'(lc), 9'h003);
		chk("compare one-two", 9'(cs), 9'h000);
		col = code(0);
		cv = 1'b1;
		@(posedge clk);
		#1 cv = 1'b0;
		repeat (4) @(posedge clk iff pulse);
		#1 chk("normal again", 9'(lc), 9'h000);
		chk("compare two-three", 9'(cs), 9'h001);
		$display("status done");
	endtask
	task automatic t_err();
		col = 6'h30;
		cv = 1'b1;
		@(posedge clk);
		#1 cv = 1'b0;
		chk("code error", 9'(err), 9'h001);
		start = 1'b1;
		@(posedge clk);
		#1 start = 1'b0;
		chk("error cleared", 9'(err), 9'h000);
		$display("code error done");
	endtask
	task automatic t_stacker();
		stacker = 1'b1;
		@(posedge clk);
		#1 chk("full stop", 9'(run), 9'h000);
		start = 1'b1;
		@(posedge clk);
		#1 start = 1'b0;
		stacker = 1'b0;
		chk("start ignored", 9'(run), 9'h000);
		start = 1'b1;
		@(posedge clk);
		#1 start = 1'b0;
		chk("restart", 9'(run), 9'h001);
		$display("stacker done");
	endtask
	task automatic t_hopper();
		@(posedge clk iff pulse);
		#1 hopper = 1'b1;
		@(posedge clk iff pulse);
		#1 chk("hopper stop", 9'(run), 9'h000);
		start = 1'b1;
		@(posedge clk);
		#1 start = 1'b0;
		hopper = 1'b0;
		chk("run out", 9'(run), 9'h001);
		$display("hopper done");
	endtask
	// fill with print stalled, then drain with stalls in between
	task automatic t_digits();
		int acc, got;
		acc = 0;
		got = 0;
		stall = 1'b1;
		digit = 9'h187; // column 24 is out of range
		dv = 1'b1;
		@(posedge clk);
		repeat (12)
		begin
			#1 digit = {5'(acc), 4'(acc + 1)};
			acc += int'(rdy);
			@(posedge clk);
		end
		#1 dv = 1'b0;
		chk("taken", 9'(acc), 9'(MLFC_FIFO_DEPTH + int'(pv)));
		for (int k = 0; k < 1200; k++)
		begin
			// look off the edge: what stands now is taken at the next
			@(posedge clk);
			#1;
			if (pv && pready)
			begin
				chk("digit", pd, {5'(got), 4'(got + 1)});
				got++;
			end
			stall = (k % 5) == 0;
		end
		chk("drained", 9'(got), 9'(acc));
		$display("digits done");
	endtask
	initial
	begin
		{arst_n, start, hopper, stacker, cv, dv, stall, held} = 8'h00;
		col = 6'h00;
		digit = 9'h000;
		order = '{2'h2, 2'h0, 2'h1};
		mismatches = 0;
		checks = 0;
		repeat (8) @(posedge clk);
		#1 arst_n = 1'b1;
		start = 1'b1;
		@(posedge clk);
		#1 start = 1'b0;
		chk("running", 9'(run), 9'h001);
		@(posedge clk iff pulse);
		#1;
		t_pairs();
		t_status();
		t_err();
		t_stacker();
		t_hopper();
		t_digits();
		summarize();
	end
	// cut a hang short well past the expected run length
	initial
	begin
		repeat (20000) @(posedge clk);
		mismatches++;
		summarize();
	end
endmodule
`default_nettype wire
